// file: hdl/voltage_variation_function.sv
// Voltage variation recorder with three rotating banks behind AXI4-Lite.
// Assumes magnitudes, classification and timestamp come from logic on i_clk.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module voltage_variation_function (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire voltage_variation_pkg::mag_t i_cur_a,
  input wire voltage_variation_pkg::mag_t i_cur_b,
  input wire voltage_variation_pkg::mag_t i_cur_c,
  input wire voltage_variation_pkg::mag_t i_volt_a,
  input wire voltage_variation_pkg::mag_t i_volt_b,
  input wire voltage_variation_pkg::mag_t i_volt_c,
  input wire logic i_sample_valid,
  input wire logic [2:0] i_swell_start,
  input wire logic [2:0] i_dip_start,
  input wire logic [2:0] i_intr_start,
  input wire logic i_detect,
  input wire logic i_max_exceeded,
  input wire logic i_block,
  input wire voltage_variation_pkg::stamp_t i_time,
  output logic o_detected,
  output logic o_present,
  output logic o_swell_active,
  output logic o_dip_active,
  output logic o_interruption_active,
  output logic o_irq,
  input wire logic [voltage_variation_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [voltage_variation_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    voltage_variation_pkg::track_state_t st;
    logic [2:0] act_q;
    voltage_variation_pkg::mag_t [2:0] cur_last;
    voltage_variation_pkg::record_t work;
    voltage_variation_pkg::record_t [2:0] bank;
    logic det;
    logic sw;
    logic dp;
    logic it;
    logic aw_ok;
    logic [voltage_variation_pkg::ADDR_W-1:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
  } state_t;

  state_t s;
  state_t next_s;
  logic [2:0] act;
  logic [2:0] upd;
  logic start_ev;
  logic commit;
  voltage_variation_pkg::mag_t [2:0] volt;

  function automatic logic [31:0] rec_word(input voltage_variation_pkg::record_t r, input logic [4:0] f);
    logic [1:0] k;
    logic [31:0] w;
    k = 2'((f - 5'h2) % 5'h3);
    w = 32'h0;
    if (f == 5'h0) begin
      w = 32'(r.det_time);
    end else if (f == 5'h1) begin
      w = 32'(r.vtype);
    end else if (f < 5'h5) begin
      w = 32'(r.extreme[k]);
    end else if (f < 5'h8) begin
      w = 32'(r.extreme_time[k]);
    end else if (f < 5'hb) begin
      w = 32'(r.duration[k]);
    end else if (f < 5'he) begin
      w = 32'(r.start_time[k]);
    end else begin
      w = 32'(r.pre_current[k]);
    end
    return w;
  endfunction

  always_comb begin
    logic [voltage_variation_pkg::ADDR_W-1:0] off;
    logic [1:0] bk;
    logic [4:0] fld;
    logic [2:0] clr;
    logic [2:0] ev;
    logic any_upd;
    off = '0;
    bk = '0;
    fld = '0;
    clr = '0;
    ev = '0;
    any_upd = 1'b0;
    next_s = s;
    volt = {i_volt_c, i_volt_b, i_volt_a}; // [R12]
    act = (i_swell_start | i_dip_start | i_intr_start) & {3{~i_block}}; // [R13] [R18]
    start_ev = (|act) & ~(|s.act_q);
    upd = '0;
    // Last sample before activation
    if (i_sample_valid) begin
      next_s.cur_last = {i_cur_c, i_cur_b, i_cur_a};
    end
    if (start_ev) begin
      next_s.work.pre_current = s.cur_last; // [R1]
      next_s.work.extreme = volt; // [R2]
      next_s.work.vtype = 3'h0;
      // Fresh record, no stamps left from the last variation
      next_s.work.extreme_time = '0;
      next_s.work.duration = '0;
      next_s.work.start_time = '0;
      next_s.st = voltage_variation_pkg::ST_TRACK;
    end else if (~(|act)) begin
      next_s.st = voltage_variation_pkg::ST_IDLE;
    end
    for (int p = 0; p < 3; p++) begin
      if (act[p] & ~s.act_q[p]) begin
        next_s.work.start_time[p] = i_time; // [R11]
        next_s.work.extreme[p] = volt[p];
        next_s.work.extreme_time[p] = i_time; // [R5]
      end else if (act[p] & i_sample_valid & ~start_ev) begin
        if (i_swell_start[p] ? (volt[p] > s.work.extreme[p]) : (volt[p] < s.work.extreme[p])) begin
          upd[p] = 1'b1; // [R3]
          next_s.work.extreme[p] = volt[p];
          next_s.work.extreme_time[p] = i_time; // [R5]
        end
      end
      if (~act[p] & s.act_q[p]) begin
        next_s.work.duration[p] = i_time - s.work.start_time[p];
      end
    end
    any_upd = |upd;
    for (int p = 0; p < 3; p++) begin
      if (any_upd & ~act[p]) begin
        next_s.work.extreme[p] = volt[p]; // [R4]
      end
    end
    next_s.work.vtype = next_s.work.vtype
      | {|(i_intr_start & act), |(i_dip_start & act), |(i_swell_start & act)}; // [R10]
    next_s.act_q = act;
    next_s.sw = |(i_swell_start & act);
    next_s.dp = |(i_dip_start & act); // [R15]
    next_s.it = |(i_intr_start & act);
    commit = i_detect & ~i_max_exceeded & ~i_block; // [R6] [R16] [R18]
    next_s.det = commit;
    if (commit) begin
      next_s.bank[2] = s.bank[1]; // [R8] [R17]
      next_s.bank[1] = s.bank[0];
      next_s.bank[0] = next_s.work; // [R9]
      next_s.bank[0].det_time = i_time;
    end
    ev[voltage_variation_pkg::IRQ_DETECT] = commit;
    ev[voltage_variation_pkg::IRQ_START] = start_ev;
    ev[voltage_variation_pkg::IRQ_OVERRUN] = i_detect & i_max_exceeded;
    // Register write path
    if (s_axi_awvalid & ~s.aw_ok) begin
      next_s.aw_ok = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~s.w_ok) begin
      next_s.w_ok = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb0 = s_axi_wstrb[0];
    end
    if (s.bvalid & s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_ok & s.w_ok & ~s.bvalid) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = voltage_variation_pkg::RESP_OKAY;
      if (s.aw_addr == voltage_variation_pkg::IRQ_STATUS_ADDR) begin
        clr = s.w_strb0 ? s.w_data[2:0] : 3'h0;
      end else if (s.aw_addr == voltage_variation_pkg::IRQ_MASK_ADDR) begin
        if (s.w_strb0) begin
          next_s.irq_mask = s.w_data[2:0];
        end
      end else begin
        next_s.bresp = voltage_variation_pkg::RESP_SLVERR;
      end
    end
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    // Register read path
    if (s.rvalid & s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid & ~s.rvalid) begin
      off = s_axi_araddr - voltage_variation_pkg::BANK_BASE_ADDR;
      bk = off[voltage_variation_pkg::BANK_SHIFT+1:voltage_variation_pkg::BANK_SHIFT];
      fld = off[6:2];
      next_s.rvalid = 1'b1;
      next_s.rdata = 32'h0;
      next_s.rresp = voltage_variation_pkg::RESP_OKAY;
      if (s_axi_araddr == voltage_variation_pkg::IRQ_STATUS_ADDR) begin
        next_s.rdata = 32'(s.irq_stat);
      end else if (s_axi_araddr == voltage_variation_pkg::IRQ_MASK_ADDR) begin
        next_s.rdata = 32'(s.irq_mask);
      end else if (s_axi_araddr == voltage_variation_pkg::LIVE_ADDR) begin
        next_s.rdata = 32'({i_block, s.it, s.dp, s.sw, s.act_q});
      end else if (s_axi_araddr >= voltage_variation_pkg::BANK_BASE_ADDR && bk < 2'h3
          && fld < 5'(voltage_variation_pkg::FIELDS)
          && off[voltage_variation_pkg::ADDR_W-1:voltage_variation_pkg::BANK_SHIFT+2] == '0
          && s_axi_araddr[1:0] == 2'h0) begin
        next_s.rdata = rec_word(s.bank[bk], fld); // [R7]
      end else begin
        next_s.rresp = voltage_variation_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.st <= voltage_variation_pkg::ST_IDLE;
      s.irq_mask <= voltage_variation_pkg::IRQ_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign o_detected = s.det; // [R14]
  assign o_present = |s.act_q;
  assign o_swell_active = s.sw;
  assign o_dip_active = s.dp;
  assign o_interruption_active = s.it;
  assign o_irq = |(s.irq_stat & s.irq_mask);
  assign s_axi_awready = ~s.aw_ok;
  assign s_axi_wready = ~s.w_ok;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_start;
    start_ev;
  endsequence
  sequence s_commit;
    commit;
  endsequence

  a_pre_current_latch: assert property (s_start |=> s.work.pre_current == $past(s.cur_last)) // [R1]
    else $error("pre-variation currents not latched");
  a_initial_voltage_hold: assert property (s_start |=> s.work.extreme == $past(volt)) // [R2]
    else $error("initial voltages not held");
  a_swell_max_track: assert property (s.act_q[0] && act[0] && i_swell_start[0] && i_sample_valid
      && !start_ev && i_volt_a > s.work.extreme[0] |=> s.work.extreme[0] == $past(i_volt_a)) // [R3]
    else $error("swell maximum not tracked");
  a_inactive_frozen: assert property (s.st == voltage_variation_pkg::ST_TRACK && !act[0] && !s.act_q[0]
      && upd == 3'h0 && !start_ev |=> $stable(s.work.extreme[0])) // [R4]
    else $error("inactive phase changed without new extreme");
  a_extreme_stamp: assert property (upd[1] |=> s.work.extreme_time[1] == $past(i_time)) // [R5]
    else $error("extreme timestamp not replaced");
  a_commit_record: assert property (s_commit |=> s.bank[0].det_time == $past(i_time)
      && s.bank[0].vtype == $past(next_s.work.vtype) && o_detected) // [R6] [R10]
    else $error("record not committed");
  a_bank_rotate: assert property (s_commit |=> s.bank[1] == $past(s.bank[0])
      && s.bank[2] == $past(s.bank[1])) // [R8]
    else $error("banks not rotated in one cycle");
  a_keep_start_time: assert property (s.act_q[2] && act[2] |=> $stable(s.work.start_time[2])) // [R11]
    else $error("active phase restamped");
  a_block_freeze: assert property (i_block |=> $stable(s.bank) && !o_detected) // [R18]
    else $error("bank changed while blocked");
  a_overrun_skip: assert property (i_detect && i_max_exceeded |=> $stable(s.bank)) // [R16]
    else $error("overlong variation recorded");
  a_dip_output: assert property ((|i_dip_start) && !i_block |=> o_dip_active) // [R15]
    else $error("dip output not raised");
  a_present_output: assert property ((|(i_swell_start | i_dip_start | i_intr_start)) && !i_block
      |=> o_present) // [R14]
    else $error("variation present not raised");
  a_no_start_blocked: assert property (i_block |=> !o_present) // [R18]
    else $error("tracking started while blocked");
  a_duration_stamp: assert property (s.act_q[0] && !act[0]
      |=> s.work.duration[0] == $past(i_time - s.work.start_time[0])) // [R9]
    else $error("duration not recorded");
  a_fresh_record: assert property (s_start |=> s.work.duration == '0) // [R9]
    else $error("stale duration kept at start");
endmodule // voltage_variation_function

// file: include/voltage_variation_pkg.sv
// Constants, types and register map of the voltage variation recorder.
// Assumes one system clock shared with the magnitude front end.
// Summary of operation
// [R1] At variation start, latch the three currents sampled just before activation.
// [R2] At variation start, hold initial voltages of all three phases.
// [R3] Track maximum for swell phases, minimum for dip or interruption phases.
// [R4] Inactive phases not tracked; snapshot their voltages whenever a new extreme lands.
// [R5] Keep per-phase timestamp of the stored extreme, replaced with each new extreme.
// [R6] Commit record only on valid detection without maximum duration exceeded.
// [R7] Exactly three record banks, numbered one to three.
// [R8] On detection shift bank two to three, one to two, new into one.
// [R9] Record: detection time, type, per phase extreme, times, duration, current.
// [R10] Type code: swell 1, dip 2, interruption 4, combinations summed.
// [R11] A phase already active keeps its start timestamp when others start.
// [R12] Voltage inputs are true RMS magnitudes, either connection type.
// [R13] Inputs: three currents, three voltages, block input; block enters blocking mode.
// [R14] Outputs: detected, present, swell active, dip active, interruption active.
// [R15] Dip active output is high while any phase shows a dip start; the code holds it low while i_block is high.
// [R16] One maximum duration applies to all types; exceeding it skips recording.
// [R17] Bank shift and new record write happen in one clock cycle.
// [R18] While blocked, no new tracking starts and no bank changes.
package voltage_variation_pkg;
  localparam int MAG_W = 16;
  localparam int TIME_W = 32;
  localparam int ADDR_W = 12;
  localparam int BANKS = 3;
  localparam int FIELDS = 17;
  typedef logic [MAG_W-1:0] mag_t;
  typedef logic [TIME_W-1:0] stamp_t;
  typedef struct packed {
    stamp_t det_time;
    logic [2:0] vtype;
    mag_t [2:0] extreme;
    stamp_t [2:0] extreme_time;
    stamp_t [2:0] duration;
    stamp_t [2:0] start_time;
    mag_t [2:0] pre_current;
  } record_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_TRACK = 2'b10
  } track_state_t;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] LIVE_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] BANK_BASE_ADDR = 12'h100;
  localparam int BANK_SHIFT = 7;
  localparam int IRQ_DETECT = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam int TYPE_SWELL = 0;
  localparam int TYPE_DIP = 1;
  localparam int TYPE_INTR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verification/mag_front_end.sv
// Measurement front end model: magnitudes and timestamps per sample.
// Assumes the bench asks for each sample with a one-cycle step pulse.
module mag_front_end (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_step,
  input wire logic [5:0][15:0] i_set,
  output logic [5:0][15:0] o_mag,
  output logic o_valid,
  output logic [31:0] o_time
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mag <= '0;
      o_valid <= 1'b0;
      o_time <= 32'h0;
    end else begin
      o_valid <= i_step;
      if (i_step) begin
        o_mag <= i_set;
        o_time <= o_time + 32'h10;
      end
    end
  end
endmodule // mag_front_end

// file: verification/tb_voltage_variation_function.sv
// Bench for the recorder: variations, bank rotation, blocking, irq.
// Assumes the front end model steps time by 0x10 per sample.
module tb_voltage_variation_function;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic step = 1'b0;
  logic det = 1'b0;
  logic mxe = 1'b0;
  logic blk = 1'b0;
  logic [2:0] sw = 3'h0;
  logic [2:0] dp = 3'h0;
  logic [2:0] it = 3'h0;
  logic [5:0][15:0] set = '0;
  logic [5:0][15:0] mag;
  logic valid;
  logic [31:0] tm;
  logic o_detected, o_present, o_swell_active, o_dip_active, o_interruption_active, o_irq;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] bresp, rresp, resp;
  logic seen;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 i_clk = ~i_clk;
  mag_front_end fe (.i_clk(i_clk), .i_rst(i_rst), .i_step(step), .i_set(set), .o_mag(mag), .o_valid(valid),
    .o_time(tm));
  voltage_variation_function dut (.i_clk(i_clk), .i_rst(i_rst), .i_cur_a(mag[3]), .i_cur_b(mag[4]),
    .i_cur_c(mag[5]), .i_volt_a(mag[0]), .i_volt_b(mag[1]), .i_volt_c(mag[2]), .i_sample_valid(valid),
    .i_swell_start(sw), .i_dip_start(dp), .i_intr_start(it), .i_detect(det), .i_max_exceeded(mxe),
    .i_block(blk), .i_time(tm), .o_detected(o_detected), .o_present(o_present),
    .o_swell_active(o_swell_active), .o_dip_active(o_dip_active),
    .o_interruption_active(o_interruption_active), .o_irq(o_irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge i_clk);
    while (awvalid || wvalid || bready) begin
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        resp = bresp;
      end
      @(posedge i_clk);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge i_clk);
    while (arvalid || rready) begin
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
      end
      @(posedge i_clk);
    end
  endtask
  task automatic rdf(input int bank, input int f, input logic [31:0] exp);
    rd(12'h100 + 12'(bank * 128 + f * 4));
    chk(d, exp);
  endtask
  task automatic smp();
    step <= 1'b1;
    @(posedge i_clk);
    step <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic end_var(input logic mx, input logic blocked);
    sw <= 3'h0;
    dp <= 3'h0;
    it <= 3'h0;
    repeat (2) @(posedge i_clk);
    mxe <= mx;
    blk <= blocked;
    det <= 1'b1;
    @(posedge i_clk);
    det <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge i_clk);
      if (o_detected === 1'b1) seen = 1'b1;
    end
    mxe <= 1'b0;
    blk <= 1'b0;
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(12'h004);
    chk(d, 32'h0);
    rd(12'h0fc);
    chk({30'h0, resp}, 32'h2);
    wr(12'h004, 32'h1);
    chk({30'h0, resp}, 32'h0);
    set <= {16'h7, 16'h6, 16'h5, 16'h64, 16'h64, 16'h64};
    smp();
    dp <= 3'h1;
    set <= {16'h7, 16'h6, 16'h9, 16'h64, 16'h60, 16'h28};
    smp();
    chk({31'h0, o_dip_active}, 32'h1);
    rd(12'h008);
    chk(d, 32'h11);
    set <= {16'h7, 16'h6, 16'h9, 16'h64, 16'h60, 16'h3c};
    smp();
    end_var(1'b0, 1'b0);
    chk({31'h0, seen}, 32'h1);
    rdf(0, 0, 32'h30);
    rdf(0, 1, 32'h2);
    rdf(0, 2, 32'h28);
    rdf(0, 3, 32'h60);
    rdf(0, 5, 32'h20);
    rdf(0, 8, 32'h20);
    rdf(0, 11, 32'h10);
    rdf(0, 14, 32'h5);
    chk({31'h0, o_irq}, 32'h1);
    wr(12'h000, 32'h1);
    chk({31'h0, o_irq}, 32'h0);
    for (int k = 1; k < 8; k++) begin
      sw <= {2'h0, k[0]};
      dp <= {1'b0, k[1], 1'b0};
      it <= {k[2], 2'h0};
      smp();
      chk({29'h0, o_interruption_active, o_dip_active, o_swell_active}, 32'(k));
      chk({31'h0, o_present}, 32'h1);
      end_var(1'b0, 1'b0);
      rdf(0, 1, 32'(k));
    end
    rdf(1, 1, 32'h6);
    rdf(2, 1, 32'h5);
    sw <= 3'h1;
    smp();
    set <= {16'h7, 16'h6, 16'h9, 16'h64, 16'h60, 16'h70};
    smp();
    end_var(1'b0, 1'b0);
    rdf(0, 2, 32'h70);
    rdf(0, 9, 32'h0);
    rdf(2, 1, 32'h6);
    rd(12'h300);
    chk({30'h0, resp}, 32'h2);
    dp <= 3'h2;
    smp();
    set <= {16'h7, 16'h6, 16'h9, 16'h64, 16'h50, 16'h70};
    smp();
    end_var(1'b1, 1'b0);
    chk({31'h0, seen}, 32'h0);
    blk <= 1'b1;
    dp <= 3'h2;
    smp();
    chk({31'h0, o_present}, 32'h0);
    end_var(1'b0, 1'b1);
    chk({31'h0, seen}, 32'h0);
    rdf(0, 1, 32'h1);
    rd(12'h000);
    chk(d, 32'h7);
    conclude();
  end
endmodule // tb_voltage_variation_function
